//--- fsvc_pkg.sv
// Package for the float special value check slice: register map, command
// field layout, IEEE single-precision constants and the flag carrier.
// Assumes a 32-bit Avalon-MM slave port with byte addressing.
package fsvc_pkg;

   // ==========================================================================
   // Register map, byte addresses.
   // ==========================================================================
   localparam logic [7:0]  ADDR_CMD      = 8'h00;
   localparam logic [7:0]  ADDR_STATUS   = 8'h04;
   localparam logic [1:0]  GPR_WIN_TAG   = 2'h1;   // Address bits [7:6] of 0x40..0x7C.
   localparam int          GPR_COUNT     = 16;
   localparam int          SEL_W         = 4;

   // ==========================================================================
   // Command word layout.
   // ==========================================================================
   localparam int          CMD_OP_POS    = 0;
   localparam int          CMD_OP_W      = 2;
   localparam int          CMD_DST_POS   = 4;
   localparam int          CMD_SRC_POS   = 8;
   localparam int          CMD_W         = 12;

   // ==========================================================================
   // Reset values.
   // ==========================================================================
   localparam logic [31:0] GPR_RST       = 32'h0000_0000;
   localparam logic [11:0] CMD_RST       = 12'h000;
   localparam logic [4:0]  STATUS_RST    = 5'h00;

   // ==========================================================================
   // Single-precision constants.
   // ==========================================================================
   localparam logic [7:0]  EXP_ZERO      = 8'h00;
   localparam logic [7:0]  EXP_TOP_A     = 8'hFD;
   localparam logic [7:0]  EXP_TOP_B     = 8'hFE;
   localparam logic [7:0]  EXP_MAX       = 8'hFF;
   localparam logic [31:0] QUIET_NAN     = 32'h7FC0_0000;
   localparam logic [30:0] INF_MAG       = 31'h7F80_0000;
   localparam logic [30:0] ZERO_MAG      = 31'h0000_0000;
   localparam logic [31:0] RCP_SEED      = 32'h7EF3_11C3;
   localparam logic [31:0] RSQ_SEED      = 32'h5F37_59DF;

   // Operations selected by the command word.
   typedef enum logic [CMD_OP_W-1:0] {
      FSVC_OP_CHK,
      FSVC_OP_RCP,
      FSVC_OP_RSQ,
      FSVC_OP_RSV
   } fsvc_op_t;

   // Status flags; bit 0 is carry, bit 4 is saturation.
   typedef struct packed {
      logic q;
      logic v;
      logic n;
      logic z;
      logic c;
   } fsvc_flags_t;

endpackage

//--- fsvc_classify.sv
// Combinational classifier and seed generator for one single-precision operand.
// Assumes its operand is stable for the cycle in which the result is used.
`timescale 1ns/100ps
module fsvc_classify
   import fsvc_pkg::*;
(
   input  wire logic [31:0] operand,
   output fsvc_flags_t      flags,
   output logic [31:0]      rcp_val,
   output logic [31:0]      rsq_val
);

   // ==========================================================================
   // Field split and class decode.
   // ==========================================================================
   wire logic        sgn     = operand[31];
   wire logic [7:0]  expo    = operand[30:23];
   wire logic        frac_nz = |operand[22:0];
   wire logic        is_nan  = (expo == EXP_MAX) && frac_nz;
   wire logic        is_inf  = (expo == EXP_MAX) && !frac_nz;
   wire logic        is_tiny = (expo == EXP_ZERO);
   wire logic        is_low  = is_tiny || (expo == EXP_TOP_A) || (expo == EXP_TOP_B);
   wire logic        is_norm = !is_nan && !is_inf && !is_low;

   // top exponents
   // The two largest finite exponents share the denormal class.
   // class to flags
   // Classes are disjoint, so each operand lights exactly one pattern.
   assign flags = '{q: 1'b0, v: is_norm, n: is_nan, z: is_low, c: is_nan};

   // ==========================================================================
   // Seed estimates from integer arithmetic on the raw bit pattern.
   // ==========================================================================
   wire logic [31:0] rcp_mag = RCP_SEED - {1'b0, operand[30:0]};
   wire logic [31:0] rsq_mag = RSQ_SEED - {1'b0, operand[31:1]};

   // reciprocal seed
   // Specials are fixed up here; large exponents would underflow, so give zero.
   assign rcp_val = is_nan  ? QUIET_NAN :
                    is_inf  ? {sgn, ZERO_MAG} :
                    is_tiny ? {sgn, INF_MAG} :
                    is_low  ? {sgn, ZERO_MAG} :
                              {sgn, rcp_mag[30:0]};

   // root reciprocal seed
   // Negative operands other than zeros and denormals have no real root and give a quiet NaN.
   assign rsq_val = is_nan  ? QUIET_NAN :
                    is_tiny ? {sgn, INF_MAG} :
                    sgn     ? QUIET_NAN :
                    is_inf  ? {1'b0, ZERO_MAG} :
                              rsq_mag;

endmodule

//--- fsvc_top.sv
// Float special value check slice: sixteen operand registers, status flags and
// a command register, all reached over an Avalon-MM slave with waitrequest.
// Assumes one clock, a synchronous active-low reset and a well-behaved master.
//
// Summary of operation
// - Check op writes no operand register and encodes operand class in C, N, V, Z.
// - Exponents 0xFD and 0xFE classify like denormals, setting only Z.
// - Reciprocal op writes a seed approximation of one over the source.
// - Root op writes a seed approximation of one over the source square root.
// - Both approximation ops set the same class flags as the check op.
// - Approximation flags come from the source operand, not the result.
// - Specials are detected in the same pass that forms the approximation.
// - Check op leaves its operand register unchanged.
`timescale 1ns/100ps
module fsvc_top
   import fsvc_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output fsvc_flags_t      sr_flags_q
);

   // ==========================================================================
   // Storage.
   // ==========================================================================
   logic [31:0]      gpr_q [GPR_COUNT];
   logic [CMD_W-1:0] cmd_q;
   fsvc_flags_t      cls_flags;
   logic [31:0]      rcp_val;
   logic [31:0]      rsq_val;

   // ==========================================================================
   // Bus decode.
   // ==========================================================================
   // A request is taken once, with waitrequest high; it completes one cycle later.
   wire logic             bus_req   = avs_read || avs_write;
   wire logic             wr_commit = avs_write && !avs_waitrequest;
   wire logic             sel_cmd   = (avs_address == ADDR_CMD);
   wire logic             sel_sr    = (avs_address == ADDR_STATUS);
   wire logic             sel_gpr   = (avs_address[7:6] == GPR_WIN_TAG) && (avs_address[1:0] == 2'h0);
   wire logic [SEL_W-1:0] gpr_idx   = avs_address[5:2];

   // Command fields; selectors are four bits, so every register is reachable.
   wire fsvc_op_t         cmd_op    = fsvc_op_t'(avs_writedata[CMD_OP_POS +: CMD_OP_W]);
   wire logic [SEL_W-1:0] cmd_dst   = avs_writedata[CMD_DST_POS +: SEL_W];
   wire logic [SEL_W-1:0] cmd_src   = avs_writedata[CMD_SRC_POS +: SEL_W];
   wire logic [31:0]      src_val   = gpr_q[cmd_src];

   // A command write with a defined operation executes at its commit edge.
   wire logic             exec      = wr_commit && sel_cmd && (cmd_op != FSVC_OP_RSV);
   wire logic             exec_chk  = exec && (cmd_op == FSVC_OP_CHK);
   wire logic             exec_apx  = exec && (cmd_op != FSVC_OP_CHK);
   wire logic [31:0]      apx_val   = (cmd_op == FSVC_OP_RSQ) ? rsq_val : rcp_val;

   // Unmapped addresses read as zero.
   wire logic [31:0]      rd_mux    = sel_cmd ? {20'h00000, cmd_q} :
                                      sel_sr  ? {27'h0000000, sr_flags_q} :
                                      sel_gpr ? gpr_q[gpr_idx] :
                                                32'h0000_0000;

   // ==========================================================================
   // Classifier and seed generator.
   // ==========================================================================
   // single pass
   // Class and both seeds come from one combinational look at the source.
   fsvc_classify u_classify (
      .operand (src_val),
      .flags   (cls_flags),
      .rcp_val (rcp_val),
      .rsq_val (rsq_val)
   );

   // ==========================================================================
   // Bus handshake.
   // ==========================================================================
   // Waitrequest drops for one cycle after a request is seen, then rises again.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= !(bus_req && avs_waitrequest);
         if (avs_read && avs_waitrequest) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   // ==========================================================================
   // Operand registers.
   // ==========================================================================
   // Software writes honour byte enables; approximation ops write the destination.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         for (int i = 0; i < GPR_COUNT; i++) begin
            gpr_q[i] <= GPR_RST;
         end
      end else if (wr_commit && sel_gpr) begin
         for (int b = 0; b < 4; b++) begin
            if (avs_byteenable[b]) begin
               gpr_q[gpr_idx][8*b +: 8] <= avs_writedata[8*b +: 8];
            end
         end
      end else if (exec_apx) begin
         // seed writeback
         // The check op never reaches this branch, so its registers stay put.
         gpr_q[cmd_dst] <= apx_val;
      end
   end

   // ==========================================================================
   // Command and status flags.
   // ==========================================================================
   // Last command word is kept for readback.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cmd_q <= CMD_RST;
      end else if (wr_commit && sel_cmd) begin
         cmd_q <= avs_writedata[CMD_W-1:0];
      end
   end

   // Software may write the flags; an executed op replaces C, N, V and Z only.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         sr_flags_q <= fsvc_flags_t'(STATUS_RST);
      end else if (wr_commit && sel_sr && avs_byteenable[0]) begin
         sr_flags_q <= fsvc_flags_t'(avs_writedata[4:0]);
      end else if (exec) begin
         // source flags
         // Flags follow the source class; saturation keeps its value.
         sr_flags_q <= '{q: sr_flags_q.q, v: cls_flags.v, n: cls_flags.n,
                         z: cls_flags.z, c: cls_flags.c};
      end
   end

   // ==========================================================================
   // Assertions and covers.
   // ==========================================================================
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   wire logic [7:0] src_exp = src_val[30:23];
   wire logic       src_nan = (src_exp == EXP_MAX) && (|src_val[22:0]);
   wire logic       src_inf = (src_exp == EXP_MAX) && !(|src_val[22:0]);
   wire logic       src_top = (src_exp == EXP_TOP_A) || (src_exp == EXP_TOP_B);
   wire logic       src_nrm = !src_nan && !src_inf && !src_top && (src_exp != EXP_ZERO);

   AST_CHK_NO_DEST: assert property (exec_chk |=> gpr_q[$past(cmd_dst)] == $past(gpr_q[cmd_dst]))
      else $error("Check op changed its destination register.");

   AST_CHK_NAN: assert property (exec_chk && src_nan |=> sr_flags_q[3:0] == 4'h5)
      else $error("Check op gave wrong flags for NaN.");

   AST_CHK_INF: assert property (exec_chk && src_inf |=> sr_flags_q[3:0] == 4'h0)
      else $error("Check op did not clear flags for infinity.");

   AST_CHK_NORMAL: assert property (exec_chk && src_nrm |=> sr_flags_q.v && !sr_flags_q.z
                                    && !sr_flags_q.c && !sr_flags_q.n)
      else $error("Check op gave wrong flags for a normal operand.");

   AST_TOP_EXP: assert property (exec && src_top |=> sr_flags_q[3:0] == 4'h2)
      else $error("Top exponent did not set only the zero flag.");

   AST_RCP_SIGN: assert property (exec && cmd_op == FSVC_OP_RCP && !src_nan
                                  |=> gpr_q[$past(cmd_dst)][31] == $past(src_val[31]))
      else $error("Reciprocal seed has the wrong sign.");

   AST_RSQ_POS: assert property (exec && cmd_op == FSVC_OP_RSQ && src_nrm && !src_val[31]
                                 |=> !gpr_q[$past(cmd_dst)][31]
                                 && gpr_q[$past(cmd_dst)][30:23] != EXP_MAX)
      else $error("Root seed of a positive normal is not a positive finite value.");

   AST_APX_INF: assert property (exec_apx && src_inf |=> sr_flags_q[3:0] == 4'h0)
      else $error("Approximation op did not clear flags for infinity.");

   AST_FLAGS_SRC: assert property (exec && cmd_op == FSVC_OP_RCP && src_exp == EXP_ZERO
                                   |=> sr_flags_q.z && !sr_flags_q.c
                                   && gpr_q[$past(cmd_dst)][30:23] == EXP_MAX)
      else $error("Reciprocal flags followed the infinite result.");

   AST_ONE_PASS: assert property (exec_apx && src_nan |=> sr_flags_q.c && sr_flags_q.n
                                  && gpr_q[$past(cmd_dst)] == QUIET_NAN)
      else $error("NaN result and NaN flags did not land on the same edge.");

   AST_SRC_KEPT: assert property (exec_chk |=> gpr_q[$past(cmd_src)] == $past(src_val))
      else $error("Check op altered its operand register.");

   AST_Q_KEPT: assert property (exec |=> $stable(sr_flags_q.q))
      else $error("An op changed the saturation flag.");

   // Every taken request gets exactly one cycle with waitrequest low.
   AST_WAIT_ONE: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("Waitrequest did not drop for exactly one cycle.");

   COV_CHK: cover property (exec_chk ##1 sr_flags_q.v);
   COV_RCP: cover property (exec && cmd_op == FSVC_OP_RCP && src_nrm);
   COV_RSQ: cover property (exec && cmd_op == FSVC_OP_RSQ && src_nrm);
   COV_TOP: cover property (exec && src_top);

endmodule

//--- tb_top.sv
// Self-checking bench for the float special value check slice.
// Assumes fsvc_pkg and fsvc_top are compiled first and one 40 MHz clock.
`timescale 1ns/100ps
module tb_top
   import fsvc_pkg::*;
;
   // ==========================================================================
   // Signals and counters.
   // ==========================================================================
   localparam int LIMIT = 20000;
   logic        mclk;
   logic        rst_b;
   logic [7:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   fsvc_flags_t sr_flags_q;
   int          miscompares;
   int          cmp_count;
   int          cycles;
   int          seed;
   logic [31:0] corner [14];

   fsvc_top i_fsvc_top (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sr_flags_q(sr_flags_q));

   // Clock of 25 ns period.
   always #12.5 mclk = ~mclk;

   // Cycle ceiling that cuts a hang short.
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         test_done();
      end
   end

   // ==========================================================================
   // Expectation functions.
   // ==========================================================================
   // class flag encoding.
   function automatic fsvc_flags_t exp_flags(input logic [31:0] x, input logic q);
      fsvc_flags_t f;
      logic [7:0]  e;
      f = 5'h00;
      f.q = q;
      e = x[30:23];
      if (e == EXP_MAX) begin
         f.c = (x[22:0] != 23'h0);
         f.n = (x[22:0] != 23'h0);
      end else if (e == EXP_ZERO || e == EXP_TOP_A || e == EXP_TOP_B) begin
         f.z = 1'h1;
      end else begin
         f.v = 1'h1;
      end
      return f;
   endfunction

   function automatic logic [31:0] exp_seed(input logic [1:0] op, input logic [31:0] x);
      logic [7:0]  e;
      logic [31:0] d;
      e = x[30:23];
      d = RCP_SEED - {1'h0, x[30:0]};
      if (e == EXP_MAX && x[22:0] != 23'h0) return QUIET_NAN;
      if (e == EXP_ZERO) return {x[31], INF_MAG};
      if (op == 2'h1) begin
         if (e == EXP_MAX || e == EXP_TOP_A || e == EXP_TOP_B) return {x[31], ZERO_MAG};
         return {x[31], d[30:0]};
      end
      if (x[31]) return QUIET_NAN;
      if (e == EXP_MAX) return 32'h0000_0000;
      return RSQ_SEED - (x >> 1);
   endfunction

   // Byte address of operand register i.
   function automatic logic [7:0] ra(input logic [3:0] i);
      return {GPR_WIN_TAG, i, 2'h0};
   endfunction

   // ==========================================================================
   // Bus tasks and comparison.
   // ==========================================================================
   task automatic test_done();
      if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // One Avalon transfer, held until waitrequest is sampled low.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be,
                      output logic [31:0] rd);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= wd;
      avs_byteenable <= be;
      @(posedge mclk);
      // Only the bench's cycle ceiling ends a wait that never finishes.
      while (avs_waitrequest !== 1'h0) begin
         @(posedge mclk);
      end
      rd = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      @(posedge mclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] x;
      bus(1'h1, a, d, be, x);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'h0, a, 32'h0000_0000, 4'hF, x);
      chk(x, e);
   endtask

   // One operation on operand x with random selectors and prior status.
   task automatic run_op(input logic [1:0] op, input logic [31:0] x);
      logic [31:0] r;
      logic [31:0] old_d;
      logic [3:0]  s;
      logic [3:0]  d;
      fsvc_flags_t f;
      r = $random(seed);
      old_d = $random(seed);
      s = r[3:0];
      d = (r[7:4] == s) ? s + 4'h1 : r[7:4];
      f = exp_flags(x, r[12]);
      if (op == 2'h3) f = r[12:8];
      wr(ra(s), x, 4'hF);
      wr(ra(d), old_d, 4'hF);
      wr(ADDR_STATUS, {27'h0, r[12:8]}, 4'h1);
      wr(ADDR_CMD, {20'h0, s, d, 2'h0, op}, 4'hF);
      rdc(ADDR_STATUS, {27'h0, f});
      chk({27'h0, sr_flags_q}, {27'h0, f});
      rdc(ra(s), x);
      rdc(ra(d), (op == 2'h1 || op == 2'h2) ? exp_seed(op, x) : old_d);
      rdc(ADDR_CMD, {20'h0, s, d, 2'h0, op});
      rdc({2'h2, r[21:16]}, 32'h0000_0000);
   endtask

   // ==========================================================================
   // Main sequence.
   // ==========================================================================
   initial begin
      logic [31:0] x;
      corner = '{32'h7FC0_0001, 32'hFFC0_0000, 32'h7F80_0000, 32'hFF80_0000, 32'h0000_0000, 32'h8000_0000,
                 32'h0040_0000, 32'h7E80_0000, 32'h7F00_0000, 32'h7EFF_FFFF, 32'h3F80_0000, 32'hC049_0FDB,
                 32'h0080_0000, 32'h7E7F_FFFF};
      seed = 47141;
      mclk = 1'h0;
      rst_b = 1'h0;
      avs_address = 8'h00;
      avs_read = 1'h0;
      avs_write = 1'h0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'h0;
      miscompares = 0;
      cmp_count = 0;
      cycles = 0;
      repeat (4) @(posedge mclk);
      rst_b <= 1'h1;
      @(posedge mclk);
      chk({27'h0, sr_flags_q}, {27'h0, STATUS_RST});
      rdc(ADDR_STATUS, {27'h0, STATUS_RST});
      rdc(ADDR_CMD, {20'h0, CMD_RST});
      for (int i = 0; i < GPR_COUNT; i++) rdc(ra(4'(i)), GPR_RST);
      // Partial byte lanes merge into an operand register.
      wr(ra(4'h3), 32'hA5A5_A5A5, 4'h5);
      rdc(ra(4'h3), 32'h00A5_00A5);
      // Every operation over the hand-picked operands.
      for (int op = 0; op < 4; op++) begin
         for (int i = 0; i < 14; i++) run_op(2'(op), corner[i]);
      end
      // Random operands, half of them pushed to exponents 0xFC through 0xFF.
      for (int k = 0; k < 60; k++) begin
         x = $random(seed);
         if (k % 2 == 0) x[30:23] = 8'hFC + 8'(k % 8 / 2);
         run_op(2'(k % 3), x);
      end
      test_done();
   end
endmodule
